/* File: rspsel_board.sv */
// Board strap resistors and pad pulls facing the strap selector
`timescale 1ns/1ps
module rspsel_board (
    input wire logic pci_strap, // Pci select resistor level
    input wire logic width_strap, // Host width resistor level
    input wire logic mac_strap, // Mac select resistor level
    input wire logic eeai_strap, // Eeprom autoinit resistor level
    input wire logic rsv_high, // Bench order to pull reserved pad high
    input wire logic [15:0] gpio_out, // Device pad outputs
    input wire logic [15:0] gpio_oe, // Device pad enables
    output logic pci_select_strap_pin, // Pci select pad
    output logic host_width_strap_pin, // Host width pad
    output logic mac_select_strap_pin, // Mac select pad
    output logic [15:0] gpio_in // Resolved gpio pad levels
);
    logic [15:0] pull;

    assign pci_select_strap_pin = pci_strap;
    assign host_width_strap_pin = width_strap;
    assign mac_select_strap_pin = mac_strap;

    // Pull-ups on spare pads, straps on bits 0 and 3
    always_comb begin
        pull = 16'hfff6;
        pull[3] = eeai_strap;
        pull[0] = rsv_high;
    end

    // Device drive wins over the board pull
    assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & pull);
endmodule : rspsel_board

/* File: rspsel_pkg.sv */
// Shared constants and types for the reset strap peripheral selector
package rspsel_pkg;

    // Owner of a group of shared host data pads
    typedef enum logic [1:0] {
        RSPSEL_OWN_HIZ,
        RSPSEL_OWN_HOST,
        RSPSEL_OWN_MAC,
        RSPSEL_OWN_PCI
    } rspsel_owner_t;

    // Wishbone geometry
    localparam int RSPSEL_ADR_W = 8;
    localparam int RSPSEL_DAT_W = 32;
    localparam int RSPSEL_GPIO_W = 16;

    // Register byte offsets
    localparam logic [7:0] RSPSEL_STATUS_OFS = 8'h00;
    localparam logic [7:0] RSPSEL_GPIO_EN_OFS = 8'h04;
    localparam logic [7:0] RSPSEL_GPIO_DIR_OFS = 8'h08;
    localparam logic [7:0] RSPSEL_GPIO_OUT_OFS = 8'h0c;
    localparam logic [7:0] RSPSEL_GPIO_IN_OFS = 8'h10;

    // Status register bit positions
    localparam int RSPSEL_ST_VALID = 0;
    localparam int RSPSEL_ST_PCI = 1;
    localparam int RSPSEL_ST_WIDTH = 2;
    localparam int RSPSEL_ST_MAC = 3;
    localparam int RSPSEL_ST_EEAI = 4;
    localparam int RSPSEL_ST_ERROR = 5;
    localparam int RSPSEL_ST_HOST = 6;
    localparam int RSPSEL_ST_WIDE = 7;
    localparam int RSPSEL_ST_ETHERNET_MAC_UNIT = 8;

    // Strap pads that double as general-purpose pins
    localparam int RSPSEL_RESERVED_LOW_BIT = 0;
    localparam int RSPSEL_EEAI_BIT = 3;

    // Shared upper general-purpose pins and implemented bit mask
    localparam int RSPSEL_UPPER_LO = 9;
    localparam int RSPSEL_LOWER_HI = 7;
    localparam logic [15:0] RSPSEL_GPIO_MASK = 16'hfeff;

    // Reset values
    localparam logic [15:0] RSPSEL_GPIO_RST = 16'h0000;
    localparam logic [31:0] RSPSEL_DAT_RST = 32'h0000_0000;

    // Edges after reset release before the synchronised straps are valid
    localparam int RSPSEL_SYNC_STAGES = 2;
    localparam logic [1:0] RSPSEL_SETTLE_CYCLES = 2'h2;

endpackage : rspsel_pkg

/* File: rspsel_sync.sv */
// Two flip-flop synchroniser for a bus of independent levels
`timescale 1ns/1ps
module rspsel_sync #(
    parameter int WIDTH = 1
) (
    input wire logic core_clk, // Device clock
    input wire logic rst_b, // Async reset, active low
    input wire logic [WIDTH-1:0] async_d, // Levels from pads
    output logic [WIDTH-1:0] sync_q // Synchronised levels
);

    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_d;
            sync_q <= meta_q;
        end
    end

endmodule : rspsel_sync

/* File: rspsel_tb.sv */
// Self-checking bench for the strap peripheral selector
`timescale 1ns/1ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_errors++; \
    $display("Error at %0t: got %h expected %h", $time, (got), (exp)); end end
module testbench;
    import rspsel_pkg::*;

    typedef struct {
        logic [3:0] st;
        logic [7:0] en;
        rspsel_owner_t lo;
        rspsel_owner_t up;
    } rspsel_row_t;

    logic core_clk, rst_b, wb_cyc, wb_stb, wb_we, wb_ack_o;
    logic [7:0] wb_adr;
    logic [3:0] wb_sel;
    logic [31:0] wb_dat, wb_dat_o, rd;
    logic pci_s, width_s, mac_s, eeai_s, rsv_high, pci_pin, width_pin, mac_pin;
    logic [15:0] gpio_in, gpio_out, gpio_oe;
    logic cfg_valid, config_error, host_port_en, wide, narrow, pci_en, pci_eeprom_load;
    logic pci_use_defaults, ethernet_mac_unit_en, mdio_en, pci_only_oe;
    rspsel_owner_t lower_owner, upper_owner;
    int n_errors = 0;
    int n_tests = 0;
    // Straps {pci, width, mac, eeai}; enables {host, wide, narrow, pci, dflt, ethernet_mac_unit, mdio, pci_only}
    rspsel_row_t rows [6] = '{
        '{4'b0000, 8'b1010_0000, RSPSEL_OWN_HOST, RSPSEL_OWN_HIZ},
        '{4'b0011, 8'b1010_0110, RSPSEL_OWN_HOST, RSPSEL_OWN_MAC},
        '{4'b0100, 8'b1100_0000, RSPSEL_OWN_HOST, RSPSEL_OWN_HOST},
        '{4'b0110, 8'b0000_0110, RSPSEL_OWN_HIZ, RSPSEL_OWN_MAC},
        '{4'b1001, 8'b0001_0001, RSPSEL_OWN_PCI, RSPSEL_OWN_PCI},
        '{4'b1110, 8'b0001_1001, RSPSEL_OWN_PCI, RSPSEL_OWN_PCI}};

    rspsel_top rspsel_top_inst (.core_clk(core_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
        .wb_dat_i(wb_dat), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
        .pci_select_strap_pin(pci_pin), .host_width_strap_pin(width_pin),
        .mac_select_strap_pin(mac_pin), .gpio_in(gpio_in), .gpio_out(gpio_out),
        .gpio_oe(gpio_oe), .cfg_valid(cfg_valid), .config_error(config_error),
        .host_port_en(host_port_en), .host_port_wide_mode(wide),
        .host_port_narrow_mode(narrow), .pci_en(pci_en), .pci_eeprom_load(pci_eeprom_load),
        .pci_use_defaults(pci_use_defaults), .ethernet_mac_unit_en(ethernet_mac_unit_en), .mdio_en(mdio_en),
        .pci_only_oe(pci_only_oe), .lower_owner(lower_owner), .upper_owner(upper_owner));

    rspsel_board rspsel_board_inst (.pci_strap(pci_s), .width_strap(width_s),
        .mac_strap(mac_s), .eeai_strap(eeai_s), .rsv_high(rsv_high), .gpio_out(gpio_out),
        .gpio_oe(gpio_oe), .pci_select_strap_pin(pci_pin), .host_width_strap_pin(width_pin),
        .mac_select_strap_pin(mac_pin), .gpio_in(gpio_in));

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test

    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        // Requests start only on a rising edge
        @(posedge core_clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_sel <= 4'h3;
        wb_we <= we;
        wb_adr <= a;
        wb_dat <= d;
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        if (n >= 20) begin
            n_errors++;
            $display("Error at %0t: no bus acknowledge", $time);
            end_of_test();
        end
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge core_clk);
    endtask : wb

    task automatic boot(input logic [3:0] st, input logic bad);
        int n;
        @(posedge core_clk);
        {pci_s, width_s, mac_s, eeai_s} <= st;
        rsv_high <= bad;
        rst_b <= 1'b0;
        @(posedge core_clk);
        #1;
        `CHK(cfg_valid, 1'b0)
        `CHK(lower_owner, RSPSEL_OWN_HIZ)
        // Release on a rising edge after two cycles of reset
        @(posedge core_clk);
        rst_b <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            #1;
            n++;
        end while (cfg_valid !== 1'b1 && n < 8);
        if (n >= 8) begin
            n_errors++;
            $display("Error at %0t: selection never valid", $time);
            end_of_test();
        end
        `CHK(pci_eeprom_load, st[3] & st[0])
        @(posedge core_clk);
        #1;
        `CHK(pci_eeprom_load, 1'b0)
    endtask : boot

    task automatic gpio_prog(input logic [15:0] oe_exp, input logic [31:0] st_exp);
        wb(1'b0, RSPSEL_GPIO_EN_OFS, '0);
        `CHK(rd, RSPSEL_DAT_RST)
        wb(1'b1, RSPSEL_GPIO_EN_OFS, 32'hffff);
        wb(1'b1, RSPSEL_GPIO_DIR_OFS, 32'hffff);
        wb(1'b1, RSPSEL_GPIO_OUT_OFS, 32'ha5a5);
        #1;
        `CHK(gpio_oe, oe_exp)
        `CHK(gpio_out, oe_exp & 16'ha5a5)
        wb(1'b1, RSPSEL_STATUS_OFS, 32'hffff);
        wb(1'b0, RSPSEL_STATUS_OFS, '0);
        `CHK(rd, st_exp)
        wb(1'b0, 8'h20, '0);
        `CHK(rd, 32'h0000_0000)
    endtask : gpio_prog

    initial begin
        rst_b = 1'b0;
        {wb_cyc, wb_stb, wb_we} = 3'b000;
        wb_adr = 8'h00;
        wb_sel = 4'h3;
        wb_dat = 32'h0;
        {pci_s, width_s, mac_s, eeai_s, rsv_high} = 5'b00000;
        foreach (rows[i]) begin
            boot(rows[i].st, 1'b0);
            `CHK({host_port_en, wide, narrow, pci_en, pci_use_defaults, ethernet_mac_unit_en, mdio_en,
                pci_only_oe}, rows[i].en)
            `CHK(lower_owner, rows[i].lo)
            `CHK(upper_owner, rows[i].up)
            `CHK(config_error, 1'b0)
            $display("Row %0d done", i);
        end
        @(posedge core_clk);
        {pci_s, width_s, mac_s, eeai_s} <= 4'b0000;
        repeat (6) @(posedge core_clk);
        #1;
        `CHK({pci_en, host_port_en, upper_owner}, {2'b10, RSPSEL_OWN_PCI})
        $display("Late strap change test done");
        boot(4'b0100, 1'b1);
        `CHK(config_error, 1'b1)
        `CHK(wide, 1'b1)
        $display("Reserved strap test done");
        boot(4'b0100, 1'b0);
        gpio_prog(RSPSEL_GPIO_MASK, 32'h0000_00c5);
        $display("Host gpio test done");
        boot(4'b1001, 1'b0);
        gpio_prog(RSPSEL_GPIO_MASK & 16'h00ff, 32'h0000_0013);
        $display("Pci gpio test done");
        end_of_test();
    end
endmodule : testbench

/* File: rspsel_top.sv */
// Reset strap capture and shared pin peripheral selection with Wishbone registers
`timescale 1ns/1ps
module rspsel_top (
    input wire logic core_clk, // Device clock, 40 MHz
    input wire logic rst_b, // Async reset, active low
    input wire logic wb_cyc_i, // Wishbone cycle
    input wire logic wb_stb_i, // Wishbone strobe
    input wire logic wb_we_i, // Wishbone write
    input wire logic [rspsel_pkg::RSPSEL_ADR_W-1:0] wb_adr_i, // Byte address
    input wire logic [3:0] wb_sel_i, // Byte selects
    input wire logic [rspsel_pkg::RSPSEL_DAT_W-1:0] wb_dat_i, // Write data
    output logic wb_ack_o, // Wishbone acknowledge
    output logic [rspsel_pkg::RSPSEL_DAT_W-1:0] wb_dat_o, // Read data
    input wire logic pci_select_strap_pin, // Pci select strap pad
    input wire logic host_width_strap_pin, // Host width strap pad
    input wire logic mac_select_strap_pin, // Mac select strap pad
    input wire logic [rspsel_pkg::RSPSEL_GPIO_W-1:0] gpio_in, // Gpio pad inputs
    output logic [rspsel_pkg::RSPSEL_GPIO_W-1:0] gpio_out, // Gpio pad outputs
    output logic [rspsel_pkg::RSPSEL_GPIO_W-1:0] gpio_oe, // Gpio pad enables
    output logic cfg_valid, // Selection decoded
    output logic config_error, // Reserved strap was high
    output logic host_port_en, // Host port enabled
    output logic host_port_wide_mode, // Host port 32 bit
    output logic host_port_narrow_mode, // Host port 16 bit
    output logic pci_en, // Pci interface enabled
    output logic pci_eeprom_load, // Start eeprom load, pulse
    output logic pci_use_defaults, // Pci keeps defaults
    output logic ethernet_mac_unit_en, // Ethernet mac unit enabled
    output logic mdio_en, // Mdio enabled
    output logic pci_only_oe, // Pci only pins may drive
    output rspsel_pkg::rspsel_owner_t lower_owner, // Owner of host_data_lower
    output rspsel_pkg::rspsel_owner_t upper_owner // Owner of host_data_upper
);
    import rspsel_pkg::*;

    // Decoded selection
    typedef struct packed {
        logic host;
        logic wide;
        logic narrow;
        logic pci;
        logic load;
        logic dflt;
        logic mac;
        logic pci_pins;
        logic gpio_up;
        rspsel_owner_t lo;
        rspsel_owner_t up;
    } rspsel_sel_t;

    logic [2:0] strap_sync;
    logic [RSPSEL_GPIO_W-1:0] gpio_sync;
    logic [1:0] settle_q;
    logic latched_q;
    logic pci_strap_q;
    logic host_width_strap_q;
    logic mac_select_strap_q;
    logic eeprom_autoinit_strap_q;
    logic reserved_low_strap_q;
    rspsel_sel_t sel;
    logic [RSPSEL_GPIO_W-1:0] gpio_enable_bits_q;
    logic [RSPSEL_GPIO_W-1:0] gpio_direction_bits_q;
    logic [RSPSEL_GPIO_W-1:0] gpio_data_q;
    logic [RSPSEL_GPIO_W-1:0] gpio_allow;
    logic wb_req;
    logic [RSPSEL_GPIO_W-1:0] wmask;

    // Maps strap levels to peripheral enables and pad owners
    function automatic rspsel_sel_t rspsel_decode(input logic pci, input logic width,
                                                  input logic mac, input logic eeai);
        rspsel_sel_t s;
        s = '0;
        s.lo = RSPSEL_OWN_HIZ;
        s.up = RSPSEL_OWN_HIZ;
        if (pci) begin
            s.pci = 1'b1;
            s.pci_pins = 1'b1;
            s.load = eeai;
            s.dflt = !eeai;
            s.lo = RSPSEL_OWN_PCI;
            s.up = RSPSEL_OWN_PCI;
        end else begin
            s.gpio_up = 1'b1;
            s.mac = mac;
            s.host = !(width && mac);
            s.wide = width && !mac;
            s.narrow = !width;
            s.lo = s.host ? RSPSEL_OWN_HOST : RSPSEL_OWN_HIZ;
            if (mac) begin
                s.up = RSPSEL_OWN_MAC;
            end else if (width) begin
                s.up = RSPSEL_OWN_HOST;
            end
        end
        return s;
    endfunction : rspsel_decode

    rspsel_sync #(
        .WIDTH(3)
    ) u_strap_sync (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .async_d({pci_select_strap_pin, host_width_strap_pin, mac_select_strap_pin}),
        .sync_q(strap_sync)
    );

    rspsel_sync #(
        .WIDTH(RSPSEL_GPIO_W)
    ) u_gpio_sync (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .async_d(gpio_in),
        .sync_q(gpio_sync)
    );

    // Wait for the synchroniser to fill after reset release
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            settle_q <= '0;
        end else if (settle_q != RSPSEL_SETTLE_CYCLES) begin
            settle_q <= settle_q + 2'h1;
        end
    end

    // One-time strap capture, held until next reset
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            latched_q <= 1'b0;
            pci_strap_q <= 1'b0;
            host_width_strap_q <= 1'b0;
            mac_select_strap_q <= 1'b0;
            eeprom_autoinit_strap_q <= 1'b0;
            reserved_low_strap_q <= 1'b0;
        end else if (!latched_q && settle_q == RSPSEL_SETTLE_CYCLES) begin
            latched_q <= 1'b1;
            pci_strap_q <= strap_sync[2];
            host_width_strap_q <= strap_sync[1];
            mac_select_strap_q <= strap_sync[0];
            eeprom_autoinit_strap_q <= gpio_sync[RSPSEL_EEAI_BIT];
            reserved_low_strap_q <= gpio_sync[RSPSEL_RESERVED_LOW_BIT];
        end
    end

    always_comb begin
        sel = rspsel_decode(pci_strap_q, host_width_strap_q,
                            mac_select_strap_q, eeprom_autoinit_strap_q);
    end

    // Selection outputs, all off until the straps are latched
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_valid <= 1'b0;
            config_error <= 1'b0;
            host_port_en <= 1'b0;
            host_port_wide_mode <= 1'b0;
            host_port_narrow_mode <= 1'b0;
            pci_en <= 1'b0;
            pci_use_defaults <= 1'b0;
            ethernet_mac_unit_en <= 1'b0;
            mdio_en <= 1'b0;
            pci_only_oe <= 1'b0;
            lower_owner <= RSPSEL_OWN_HIZ;
            upper_owner <= RSPSEL_OWN_HIZ;
        end else begin
            cfg_valid <= latched_q;
            config_error <= latched_q && reserved_low_strap_q;
            host_port_en <= latched_q && sel.host;
            host_port_wide_mode <= latched_q && sel.host && sel.wide;
            host_port_narrow_mode <= latched_q && sel.host && sel.narrow;
            pci_en <= latched_q && sel.pci;
            pci_use_defaults <= latched_q && sel.dflt;
            ethernet_mac_unit_en <= latched_q && sel.mac;
            mdio_en <= latched_q && sel.mac;
            pci_only_oe <= latched_q && sel.pci_pins;
            lower_owner <= latched_q ? sel.lo : RSPSEL_OWN_HIZ;
            upper_owner <= latched_q ? sel.up : RSPSEL_OWN_HIZ;
        end
    end

    // Eeprom load request, once per reset
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pci_eeprom_load <= 1'b0;
        end else begin
            pci_eeprom_load <= latched_q && !cfg_valid && sel.load;
        end
    end

    // Upper shared pins only usable as gpio without pci
    generate
        for (genvar i = 0; i < RSPSEL_GPIO_W; i++) begin : g_allow
            if (i >= RSPSEL_UPPER_LO) begin : g_up
                assign gpio_allow[i] = cfg_valid && sel.gpio_up;
            end else begin : g_lo
                assign gpio_allow[i] = RSPSEL_GPIO_MASK[i];
            end
        end
    endgenerate

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            gpio_oe <= RSPSEL_GPIO_RST;
            gpio_out <= RSPSEL_GPIO_RST;
        end else begin
            gpio_oe <= gpio_enable_bits_q & gpio_direction_bits_q & gpio_allow;
            gpio_out <= gpio_data_q & gpio_allow;
        end
    end

    // Wishbone slave, one wait state, answers every address
    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}} & RSPSEL_GPIO_MASK;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            gpio_enable_bits_q <= RSPSEL_GPIO_RST;
            gpio_direction_bits_q <= RSPSEL_GPIO_RST;
            gpio_data_q <= RSPSEL_GPIO_RST;
        end else if (wb_req && wb_we_i) begin
            if (wb_adr_i == RSPSEL_GPIO_EN_OFS) begin
                gpio_enable_bits_q <= (gpio_enable_bits_q & ~wmask)
                                      | (wb_dat_i[15:0] & wmask);
            end else if (wb_adr_i == RSPSEL_GPIO_DIR_OFS) begin
                gpio_direction_bits_q <= (gpio_direction_bits_q & ~wmask)
                                         | (wb_dat_i[15:0] & wmask);
            end else if (wb_adr_i == RSPSEL_GPIO_OUT_OFS) begin
                gpio_data_q <= (gpio_data_q & ~wmask) | (wb_dat_i[15:0] & wmask);
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wb_dat_o <= RSPSEL_DAT_RST;
        end else if (wb_req && !wb_we_i) begin
            wb_dat_o <= RSPSEL_DAT_RST;
            if (wb_adr_i == RSPSEL_STATUS_OFS) begin
                wb_dat_o[RSPSEL_ST_VALID] <= cfg_valid;
                wb_dat_o[RSPSEL_ST_PCI] <= pci_strap_q;
                wb_dat_o[RSPSEL_ST_WIDTH] <= host_width_strap_q;
                wb_dat_o[RSPSEL_ST_MAC] <= mac_select_strap_q;
                wb_dat_o[RSPSEL_ST_EEAI] <= eeprom_autoinit_strap_q;
                wb_dat_o[RSPSEL_ST_ERROR] <= config_error;
                wb_dat_o[RSPSEL_ST_HOST] <= host_port_en;
                wb_dat_o[RSPSEL_ST_WIDE] <= host_port_wide_mode;
                wb_dat_o[RSPSEL_ST_ETHERNET_MAC_UNIT] <= ethernet_mac_unit_en;
            end else if (wb_adr_i == RSPSEL_GPIO_EN_OFS) begin
                wb_dat_o[15:0] <= gpio_enable_bits_q;
            end else if (wb_adr_i == RSPSEL_GPIO_DIR_OFS) begin
                wb_dat_o[15:0] <= gpio_direction_bits_q;
            end else if (wb_adr_i == RSPSEL_GPIO_OUT_OFS) begin
                wb_dat_o[15:0] <= gpio_data_q;
            end else if (wb_adr_i == RSPSEL_GPIO_IN_OFS) begin
                wb_dat_o[15:0] <= gpio_sync & RSPSEL_GPIO_MASK;
            end
        end
    end

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    sequence s_capture;
        !latched_q ##1 latched_q;
    endsequence

    sequence s_settled;
        cfg_valid && $past(cfg_valid);
    endsequence

    strap_hold_a: assert property (latched_q |=> latched_q
        && $stable(pci_strap_q) && $stable(host_width_strap_q) && $stable(mac_select_strap_q))
        else $error("latched straps changed after capture");

    pad_exclusive_a: assert property ($onehot0({host_port_wide_mode, ethernet_mac_unit_en, pci_en}))
        else $error("two peripherals own the upper pads");

    lower_gpio_a: assert property (##1 gpio_oe[RSPSEL_LOWER_HI:1] ==
        ($past(gpio_enable_bits_q[7:1]) & $past(gpio_direction_bits_q[7:1])))
        else $error("lower gpio enable not honoured");

    host_route_a: assert property (s_capture ##1 !pci_strap_q |-> lower_owner != RSPSEL_OWN_PCI
        && (host_port_en == !(host_width_strap_q && mac_select_strap_q)))
        else $error("host port routing wrong with pci off");

    pci_only_a: assert property (cfg_valid |-> pci_only_oe == pci_en)
        else $error("pci only pins driven without pci");

    host_mode_a: assert property ((s_settled and (!pci_en && !ethernet_mac_unit_en)) |->
        host_port_en && (host_port_wide_mode == (upper_owner == RSPSEL_OWN_HOST))
        && (host_port_narrow_mode != host_port_wide_mode))
        else $error("host width mode wrong");

    mac_upper_a: assert property ((s_settled and ethernet_mac_unit_en) |-> upper_owner == RSPSEL_OWN_MAC
        && mdio_en && (lower_owner == (host_width_strap_q ? RSPSEL_OWN_HIZ : RSPSEL_OWN_HOST)))
        else $error("mac pad routing wrong");

    upper_gpio_a: assert property (cfg_valid && !pci_strap_q && gpio_enable_bits_q[15]
        && gpio_direction_bits_q[15] |=> gpio_oe[15])
        else $error("upper gpio not driven when enabled");

    pci_route_a: assert property (s_capture ##1 pci_strap_q |-> pci_en && !host_port_en
        && lower_owner == RSPSEL_OWN_PCI && upper_owner == RSPSEL_OWN_PCI)
        else $error("pci routing wrong");

    pci_gpio_off_a: assert property (pci_en |-> gpio_oe[15:9] == 7'h00 && !ethernet_mac_unit_en)
        else $error("upper gpio or mac active under pci");

    eeprom_load_a: assert property (s_capture ##1 (pci_strap_q && eeprom_autoinit_strap_q)
        |-> pci_eeprom_load ##1 !pci_eeprom_load [*4])
        else $error("eeprom load pulse wrong");

    pci_default_a: assert property (cfg_valid && pci_en |->
        pci_use_defaults == !eeprom_autoinit_strap_q)
        else $error("pci default selection wrong");

    decode_stable_a: assert property (s_settled |-> $stable(lower_owner)
        && $stable(upper_owner) && $stable(host_port_en) && $stable(pci_en))
        else $error("selection changed after reset");

endmodule : rspsel_top
